// >>> pmc_map.svh
// register map, field positions, reset values and timing counts
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_TRIG_ADDR 16'h22F0
`define PMC_CTRL_ADDR 16'h22F1
`define PMC_IVL_ADDR 16'h22F3
`define PMC_DLY_ADDR 16'h22F4
`define PMC_CPU_ADDR 16'h0087
`define PMC_CTRL_RST 8'hC8
`define PMC_DLY_RST 8'h11
`define PMC_IVL_RST 8'h01
`define PMC_TRIG_BIT 0
`define PMC_HALT_BIT 1
`define PMC_IDLE_BIT 0
`define PMC_AREG_EN_BIT 7
`define PMC_AREG_OK_EN_BIT 6
`define PMC_AREG_OK_BIT 5
`define PMC_TRIG_CYC 2
`define PMC_HW_WAKE_US 1001
`define PMC_CLK_MHZ 40
`define PMC_HW_WAKE_CYC (`PMC_HW_WAKE_US * `PMC_CLK_MHZ)
`endif

// >>> pmc_pkg.sv
// types of the power mode controller
package pmc_pkg;
   typedef enum logic [1:0] {
      NORMAL_RUN = 2'h0,
      LIGHT_SLEEP = 2'h1,
      DEEP_SLEEP = 2'h2,
      DEEPEST_SLEEP = 2'h3
   } pmc_mode_type;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_ARM = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE = 4'h8
   } pmc_fsm_type;
   // pin order: 0 hardware wake, 1 external irq, 2 timer irq, 3 tick
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] f;
   } pmc_sync_type;
   typedef struct packed {
      pmc_fsm_type st;
      logic [7:0] ctrl;
      logic [7:0] dly;
      logic [7:0] ivl;
      logic trig;
      logic trig_cnt;
      logic halt;
      logic idle;
      logic cause_hw;
      logic tick;
      logic [15:0] cnt;
      logic [7:0] rdata;
      pmc_sync_type sy;
      logic areg;
      logic dreg;
      logic osc;
      logic stim;
      logic hold;
      logic cpu_clk;
      logic core_clk;
      logic periph_clk;
   } pmc_regs_type;
endpackage : pmc_pkg

// >>> pmc_power_mode_controller.sv
// chip power mode controller with cpu halt and idle clock gating
// What this block does
// - two-bit mode field: 0 normal run, 1..3 the three sleep modes.
// - modes 1,2 wake on reset, timer or external irq; mode 3 no timer.
// - supplies, oscillator and sleep timer gated per mode.
// - hardware reset wake resumes after about 1001 us.
// - timer wake latency from interval and delay; delay at least 0x11 (not clamped here: any written value is used).
// - timer wake from mode 1 or 2 takes about 534 us at least.
// - instruction fetch held off for the wake delay after any sleep.
// - cpu halt bit stops every cpu clock.
// - a wake-enabled interrupt ends cpu halt.
// - idle bit stops core clocks, peripherals keep running.
// - a non-timer non-external interrupt clears idle.
// - trigger bit clears itself two cycles after the write.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_power_mode_controller
   import pmc_pkg::*;
#(
   parameter int HW_WAKE_CYC = `PMC_HW_WAKE_CYC
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [15:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic HW_WAKE,
   input wire logic EXT_WAKE,
   input wire logic TIMER_WAKE,
   input wire logic SLEEP_TICK,
   input wire logic WAKE_IRQ,
   input wire logic OTHER_IRQ,
   output logic ANALOG_REG_EN,
   output logic DIGITAL_REG_EN,
   output logic MAIN_OSC_EN,
   output logic SLEEP_TIMER_EN,
   output logic FETCH_HOLD,
   output logic CPU_CLK_EN,
   output logic CORE_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic [7:0] WAKE_INTERVAL
);
   pmc_regs_type q;
   pmc_regs_type d;
   // reset image is built from constants only, so the async branch stays clean
   localparam pmc_regs_type rst_val = '{
      st: ST_RUN,
      ctrl: `PMC_CTRL_RST,
      dly: `PMC_DLY_RST,
      ivl: `PMC_IVL_RST,
      areg: 1'b1,
      dreg: 1'b1,
      osc: 1'b1,
      stim: 1'b1,
      cpu_clk: 1'b1,
      core_clk: 1'b1,
      periph_clk: 1'b1,
      default: '0
   };
   pmc_mode_type mode;
   logic wr_trig;
   logic wr_cpu;
   logic same;

   assign mode = pmc_mode_type'(q.ctrl[1:0]);
   assign wr_trig = WR && ADDR == `PMC_TRIG_ADDR;
   assign wr_cpu = WR && ADDR == `PMC_CPU_ADDR;

   always_comb begin
      same = 1'b0;
      d = q;
      // three-stage sync; a level counts once stages two and three agree
      d.sy.s1 = {SLEEP_TICK, TIMER_WAKE, EXT_WAKE, HW_WAKE};
      d.sy.s2 = q.sy.s1;
      d.sy.s3 = q.sy.s2;
      for (int i = 0; i < 4; i++) begin
         same = q.sy.s2[i] == q.sy.s3[i];
         d.sy.f[i] = same ? q.sy.s3[i] : q.sy.f[i];
      end
      d.tick = q.sy.f[3];

      // register writes
      if (WR) begin
         case (ADDR)
            `PMC_CTRL_ADDR: begin
               d.ctrl = WDATA;
               d.ctrl[`PMC_AREG_OK_BIT] = 1'b0;
            end
            `PMC_DLY_ADDR: d.dly = WDATA;
            `PMC_IVL_ADDR: d.ivl = WDATA;
            default: ;
         endcase
      end

      // cpu halt and idle: hardware clears, a software set the same cycle wins
      if (WAKE_IRQ) begin
         d.halt = 1'b0;
      end
      if (OTHER_IRQ) begin
         d.idle = 1'b0;
      end
      if (wr_cpu) begin
         d.halt = WDATA[`PMC_HALT_BIT];
         d.idle = WDATA[`PMC_IDLE_BIT];
      end

      // chip power state machine
      case (q.st)
         ST_RUN: begin
            if (wr_trig && WDATA[`PMC_TRIG_BIT]) begin
               d.trig = 1'b1;
               d.trig_cnt = 1'b0;
               d.st = ST_ARM;
            end
         end
         ST_ARM: begin
            // trigger stands two cycles, then the selected mode is taken
            d.trig_cnt = 1'b1;
            if (q.trig_cnt) begin
               d.trig = 1'b0;
               d.st = (mode == NORMAL_RUN) ? ST_RUN : ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            d.cnt = '0;
            if (q.sy.f[0] || q.sy.f[1] ||
                (q.sy.f[2] && mode != DEEPEST_SLEEP)) begin
               d.cause_hw = q.sy.f[0];
               d.st = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (q.cause_hw) begin
               // reset wake uses a fixed system clock count
               d.cnt = q.cnt + 16'h0001;
               if (q.cnt >= 16'(HW_WAKE_CYC - 1)) begin
                  d.st = ST_RUN;
               end
            end else if (q.cnt >= {8'h00, q.dly}) begin
               d.st = ST_RUN;
            end else if (q.sy.f[3] && !q.tick) begin
               // slow clock keeps running while the crystal settles
               d.cnt = q.cnt + 16'h0001;
            end
            if (d.st == ST_RUN) begin
               d.halt = 1'b0;
            end
         end
         default: d.st = ST_RUN;
      endcase

      // supply, oscillator and clock gating, registered from next state
      d.areg = d.ctrl[`PMC_AREG_EN_BIT];
      d.dreg = 1'b1;
      d.osc = 1'b1;
      d.stim = 1'b1;
      if (d.st == ST_SLEEP) begin
         d.areg = 1'b0;
         d.osc = 1'b0;
         d.dreg = mode == LIGHT_SLEEP;
         d.stim = mode != DEEPEST_SLEEP;
      end
      d.hold = d.st != ST_RUN;
      d.cpu_clk = !d.halt && !d.hold;
      d.core_clk = !d.halt && !d.idle && !d.hold;
      d.periph_clk = !d.halt && !d.hold;

      // read data stands one cycle after the strobe, unmapped reads zero
      d.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            `PMC_TRIG_ADDR: d.rdata = {7'h00, q.trig};
            `PMC_CTRL_ADDR: begin
               d.rdata = q.ctrl;
               d.rdata[`PMC_AREG_OK_BIT] =
                  q.areg && q.ctrl[`PMC_AREG_OK_EN_BIT];
            end
            `PMC_IVL_ADDR: d.rdata = q.ivl;
            `PMC_DLY_ADDR: d.rdata = q.dly;
            `PMC_CPU_ADDR: d.rdata = {6'h00, q.halt, q.idle};
            default: d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         q <= rst_val;
      end else begin
         q <= d;
      end
   end

   assign RDATA = q.rdata;
   assign ANALOG_REG_EN = q.areg;
   assign DIGITAL_REG_EN = q.dreg;
   assign MAIN_OSC_EN = q.osc;
   assign SLEEP_TIMER_EN = q.stim;
   assign FETCH_HOLD = q.hold;
   assign CPU_CLK_EN = q.cpu_clk;
   assign CORE_CLK_EN = q.core_clk;
   assign PERIPH_CLK_EN = q.periph_clk;
   assign WAKE_INTERVAL = q.ivl;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   property p_trig_two;
      $rose(q.trig) |-> q.trig ##1 q.trig ##1 !q.trig;
   endproperty
   a_trig_two: assert property (p_trig_two)
      else $error("trigger bit not cleared after two cycles");

   property p_enter;
      (q.st == ST_ARM && q.trig_cnt && mode != NORMAL_RUN)
         |=> q.st == ST_SLEEP && !MAIN_OSC_EN;
   endproperty
   a_enter: assert property (p_enter)
      else $error("selected sleep mode not entered");

   property p_no_timer_pm3;
      (q.st == ST_SLEEP && mode == DEEPEST_SLEEP
         && !q.sy.f[0] && !q.sy.f[1]) |=> q.st == ST_SLEEP;
   endproperty
   a_no_timer_pm3: assert property (p_no_timer_pm3)
      else $error("deepest sleep left without a valid source");

   property p_wake_src;
      (q.st == ST_SLEEP && (q.sy.f[0] || q.sy.f[1]))
         |=> q.st == ST_WAKE && FETCH_HOLD;
   endproperty
   a_wake_src: assert property (p_wake_src)
      else $error("wake source ignored in sleep");

   property p_supply;
      (q.st == ST_SLEEP && mode == DEEPEST_SLEEP)
         |-> !SLEEP_TIMER_EN && !DIGITAL_REG_EN && !ANALOG_REG_EN;
   endproperty
   a_supply: assert property (p_supply)
      else $error("supply left on in deepest sleep");

   property p_hold;
      q.st != ST_RUN |-> FETCH_HOLD && !CPU_CLK_EN;
   endproperty
   a_hold: assert property (p_hold)
      else $error("fetch not held outside run");

   property p_hw_time;
      (q.st == ST_WAKE && q.cause_hw)
         |-> q.cnt < 16'(HW_WAKE_CYC);
   endproperty
   a_hw_time: assert property (p_hw_time)
      else $error("reset wake exceeded its count");

   property p_delay;
      (q.st == ST_WAKE && !q.cause_hw) |-> q.cnt <= {8'h00, q.dly};
   endproperty
   a_delay: assert property (p_delay)
      else $error("wake delay overrun");

   property p_halt;
      q.halt |-> !CPU_CLK_EN && !PERIPH_CLK_EN;
   endproperty
   a_halt: assert property (p_halt)
      else $error("cpu clock running while halted");

   property p_wake_irq;
      (WAKE_IRQ && !wr_cpu) |=> !q.halt;
   endproperty
   a_wake_irq: assert property (p_wake_irq)
      else $error("interrupt did not end halt");

   property p_idle;
      (q.idle && !q.halt && !FETCH_HOLD)
         |-> !CORE_CLK_EN && PERIPH_CLK_EN;
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle gating wrong");

   property p_other;
      (OTHER_IRQ && !wr_cpu) |=> !q.idle;
   endproperty
   a_other: assert property (p_other)
      else $error("interrupt did not end idle");

   property p_run_supply;
      q.st == ST_RUN |-> MAIN_OSC_EN && DIGITAL_REG_EN && SLEEP_TIMER_EN;
   endproperty
   a_run_supply: assert property (p_run_supply)
      else $error("supply off in normal run");

   property p_light;
      (q.st == ST_SLEEP && mode == LIGHT_SLEEP)
         |-> DIGITAL_REG_EN && SLEEP_TIMER_EN && !MAIN_OSC_EN;
   endproperty
   a_light: assert property (p_light)
      else $error("light sleep gating wrong");

   property p_tick_only;
      (q.st == ST_WAKE && !q.cause_hw && !(q.sy.f[3] && !q.tick))
         |=> q.cnt == $past(q.cnt);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("wake delay moved without a slow clock edge");
endmodule : pmc_power_mode_controller
`default_nettype wire

// >>> pmc_wake_model.sv
// far-side model: wake pins and the free-running slow sleep clock
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_model #(
   parameter int HALF = 4
) (
   input wire logic clk,
   input wire logic [2:0] req,
   output logic hw_wake,
   output logic ext_wake,
   output logic timer_wake,
   output logic sleep_tick
);
   initial begin
      sleep_tick = 1'b0;
      // the slow clock never stops, so a wake delay always runs out
      forever begin
         repeat (HALF) @(posedge clk);
         sleep_tick <= ~sleep_tick;
      end
   end
   // wake sources are plain levels; the core side decides how long
   always @(posedge clk) begin
      hw_wake <= req[0];
      ext_wake <= req[1];
      timer_wake <= req[2];
   end
endmodule : pmc_wake_model
`default_nettype wire

// >>> tb_pmc_power_mode_controller.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_pmc_power_mode_controller;
   localparam int HWC = 20;
   logic clk, rst, wr, rd, wirq, oirq;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, ivl, o;
   logic [2:0] req;
   logic hw, ext, tmr, tick, areg, dreg, osc, stim, hold, cpu, core, per;
   int errors, checks_done, n;
   logic [15:0] ra [6] = '{16'h22F0, 16'h22F1, 16'h22F3, 16'h22F4,
      16'h0087, 16'h1234};
   logic [7:0] rv [6] = '{8'h00, 8'hE8, 8'h01, 8'h11, 8'h00, 8'h00};
   assign o = {areg, dreg, osc, stim, hold, cpu, core, per};
   pmc_power_mode_controller #(.HW_WAKE_CYC(HWC))
      pmc_power_mode_controller_inst (
      .SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .HW_WAKE(hw), .EXT_WAKE(ext),
      .TIMER_WAKE(tmr), .SLEEP_TICK(tick), .WAKE_IRQ(wirq),
      .OTHER_IRQ(oirq), .ANALOG_REG_EN(areg), .DIGITAL_REG_EN(dreg),
      .MAIN_OSC_EN(osc), .SLEEP_TIMER_EN(stim), .FETCH_HOLD(hold),
      .CPU_CLK_EN(cpu), .CORE_CLK_EN(core), .PERIPH_CLK_EN(per),
      .WAKE_INTERVAL(ivl));
   pmc_wake_model pmc_wake_model_inst (.clk(clk), .req(req),
      .hw_wake(hw), .ext_wake(ext), .timer_wake(tmr), .sleep_tick(tick));
   task automatic give_verdict();
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // bus tasks start on a rising edge and let one edge pass after the strobe
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      if (!clk) @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] v);
      if (!clk) @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, v);
      @(posedge clk);
   endtask : rd_reg
   task automatic tick_n(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask : tick_n
   // cycles until fetch is released, judged against a window
   task automatic wait_run(input int lo, input int hi);
      n = 0;
      while (n <= hi) begin
         @(negedge clk);
         if (hold === 1'b0) break;
         n++;
      end
      @(posedge clk);
      chk(8'(n >= lo && n <= hi), 8'h01);
      if (n > hi) give_verdict();
   endtask : wait_run
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      {wr, rd, wirq, oirq, addr, wdata, req} = '0;
      errors = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(o, 8'hF7);
      wr_reg(16'h1234, 8'hFF);
      for (int i = 0; i < 6; i++) rd_reg(ra[i], rv[i]);
      wr_reg(16'h22F3, 8'h05);
      rd_reg(16'h22F3, 8'h05);
      chk(ivl, 8'h05);
      for (int m = 0; m < 4; m++) begin
         wr_reg(16'h22F1, 8'hC8 | 8'(m));
         if (m != 0) wr_reg(16'h0087, 8'h02);
         wr_reg(16'h22F0, 8'h01);
         tick_n(0);
         chk(o & 8'h8C, 8'h88);
         tick_n(1);
         if (m == 0) begin
            chk(o & 8'hF0, 8'hF0);
            wait_run(0, 3);
            continue;
         end
         chk(o, {1'b0, 1'(m == 1), 1'b0, 1'(m != 3), 4'h8});
         rd_reg(16'h22F0, 8'h00);
         if (m == 3) begin
            req <= 3'b100;
            tick_n(30);
            chk(o, 8'h08);
            req <= 3'b000;
            tick_n(6);
         end
         // the wake level stays up until fetch is released
         req <= (m == 1) ? 3'b100 : (m == 2) ? 3'b010 : 3'b001;
         if (m == 3) wait_run(HWC, HWC + 12);
         else wait_run(128, 160);
         req <= 3'b000;
         tick_n(2);
         chk(o, 8'hF7);
         tick_n(6);
      end
      wr_reg(16'h0087, 8'h01);
      tick_n(2);
      chk({5'h0, cpu, core, per}, 8'h05);
      oirq <= 1'b1;
      @(posedge clk);
      oirq <= 1'b0;
      tick_n(2);
      chk({5'h0, cpu, core, per}, 8'h07);
      rd_reg(16'h0087, 8'h00);
      wr_reg(16'h0087, 8'h02);
      tick_n(2);
      chk({5'h0, cpu, core, per}, 8'h00);
      wirq <= 1'b1;
      @(posedge clk);
      wirq <= 1'b0;
      tick_n(2);
      chk({5'h0, cpu, core, per}, 8'h07);
      give_verdict();
   end
endmodule : tb_pmc_power_mode_controller
`default_nettype wire
